/* File: tb/piet_cpu_model.sv */
// Purpose: CPU core stand-in that accepts presented interrupt requests
// Assumes: Ack is a one-cycle pulse raised only while irq_req is high
// Notes:   ack_gap gives prompt (0) or slow (up to 3) acceptance
`timescale 1ns/1ns
module piet_cpu_model
   import piet_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   go,
   input  wire logic [1:0]             ack_gap,
   input  wire logic                   irq_req,
   input  wire logic [PIET_VEC_W-1:0]  irq_vector,
   input  wire logic [PIET_PRIO_W-1:0] irq_prio,
   input  wire logic                   irq_trap,
   output logic                        cpu_ack,
   output logic [7:0]                  ack_cnt_ff,
   output logic [PIET_VEC_W-1:0]       last_vec_ff,
   output logic [PIET_PRIO_W-1:0]      last_prio_ff,
   output logic                        last_trap_ff
);
   logic       ack_ff;
   logic [1:0] wait_ff;

   assign cpu_ack = ack_ff;

   //------------------------------------------------------------------
   // Acceptance: one pulse, then one idle cycle, with no wait for the request to drop
   //------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_ff       <= 1'b0;
         wait_ff      <= 2'h0;
         ack_cnt_ff   <= 8'h00;
         last_vec_ff  <= '0;
         last_prio_ff <= '0;
         last_trap_ff <= 1'b0;
      end else if (ack_ff) begin
         ack_ff  <= 1'b0;
         wait_ff <= 2'h0;
      end else if (go && irq_req) begin
         if (wait_ff == ack_gap) begin
            ack_ff       <= 1'b1;
            ack_cnt_ff   <= ack_cnt_ff + 8'h01;
            last_vec_ff  <= irq_vector;
            last_prio_ff <= irq_prio;
            last_trap_ff <= irq_trap;
         end else begin
            wait_ff <= wait_ff + 2'h1;
         end
      end else begin
         wait_ff <= 2'h0;
      end
   end
endmodule : piet_cpu_model

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the interrupt and transfer block
// Assumes: Inputs driven by non-blocking assignment at rising edges
// Notes:   Acks come from the CPU stand-in model
`timescale 1ns/1ns
module tb_top;
   import piet_pkg::*;
   logic        clk, sys_rst, node_wr, node_enable, node_evt_en;
   logic        node_set_req, chan_wr, chan_inc_src, chan_inc_dst;
   logic        chan_word, chan_cont, cpu_ack, trap_req, irq_req;
   logic        irq_trap, xfer_valid, xfer_word, cpu_stall, cpu_go;
   logic        last_trap;
   logic [15:0] periph_req, chan_src, chan_dst, xfer_src, xfer_dst;
   logic [15:0] node_request_bit;
   logic [7:0]  ext_edge_sel, chan_count, ack_cnt;
   logic [3:0]  ext_pin, node_sel, node_prio, cpu_level, irq_prio;
   logic [3:0]  last_prio;
   logic [2:0]  node_evt_chan, chan_sel;
   logic [1:0]  ack_gap;
   logic [6:0]  trap_num;
   logic [8:0]  irq_vector, last_vec;
   logic [15:0] xs[$], xd[$];
   logic        xw[$];
   int          error_cnt, check_count, k;
   logic [7:0]  n0;
   logic [15:0] es[5] = '{16'h1000, 16'h1001, 16'h1002, 16'h3000, 16'h3000};
   logic [15:0] ed[5] = '{16'h2000, 16'h2000, 16'h2000, 16'h4000, 16'h4002};
   logic [4:0]  ew = 5'h18;

   piet_ctrl u_piet_ctrl (.periph_req(periph_req), .clk(clk),
      .sys_rst(sys_rst), .ext_pin(ext_pin), .ext_edge_sel(ext_edge_sel),
      .node_wr(node_wr), .node_sel(node_sel), .node_enable(node_enable),
      .node_prio(node_prio), .node_evt_en(node_evt_en),
      .node_evt_chan(node_evt_chan), .node_set_req(node_set_req),
      .chan_wr(chan_wr), .chan_sel(chan_sel), .chan_src(chan_src),
      .chan_dst(chan_dst), .chan_count(chan_count),
      .chan_inc_src(chan_inc_src), .chan_inc_dst(chan_inc_dst),
      .chan_word(chan_word), .chan_cont(chan_cont), .cpu_level(cpu_level),
      .cpu_ack(cpu_ack), .trap_req(trap_req), .trap_num(trap_num),
      .irq_req(irq_req), .irq_vector(irq_vector), .irq_prio(irq_prio),
      .irq_trap(irq_trap), .xfer_valid(xfer_valid), .xfer_src(xfer_src),
      .xfer_dst(xfer_dst), .xfer_word(xfer_word), .cpu_stall(cpu_stall),
      .node_request_bit(node_request_bit));

   piet_cpu_model u_piet_cpu_model (.clk(clk), .sys_rst(sys_rst),
      .go(cpu_go), .ack_gap(ack_gap), .irq_req(irq_req),
      .irq_vector(irq_vector), .irq_prio(irq_prio), .irq_trap(irq_trap),
      .cpu_ack(cpu_ack), .ack_cnt_ff(ack_cnt), .last_vec_ff(last_vec),
      .last_prio_ff(last_prio), .last_trap_ff(last_trap));

   //------------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wrap_up();
      if (error_cnt == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   function automatic logic [8:0] vec(input int i);
      return {PIET_TRAP_BASE + 7'(i), PIET_VEC_LSB};
   endfunction : vec

   task automatic ncfg(input int i, input logic [3:0] pr, input logic ev,
                       input logic [2:0] ch, input logic sr);
      @(posedge clk);
      node_wr       <= 1'b1;
      node_sel      <= 4'(i);
      node_enable   <= 1'b1;
      node_prio     <= pr;
      node_evt_en   <= ev;
      node_evt_chan <= ch;
      node_set_req  <= sr;
      @(posedge clk);
      node_wr      <= 1'b0;
      node_set_req <= 1'b0;
   endtask : ncfg

   task automatic ccfg(input logic [2:0] ch, input logic [15:0] s, d,
                       input logic [7:0] c, input logic [3:0] m);
      @(posedge clk);
      chan_wr      <= 1'b1;
      chan_sel     <= ch;
      chan_src     <= s;
      chan_dst     <= d;
      chan_count   <= c;
      {chan_inc_src, chan_inc_dst, chan_word, chan_cont} <= m;
      @(posedge clk);
      chan_wr <= 1'b0;
   endtask : ccfg

   task automatic pulse(input logic [15:0] m);
      @(posedge clk);
      periph_req <= m;
      @(posedge clk);
      periph_req <= 16'h0000;
      repeat (4) @(posedge clk);
   endtask : pulse

   task automatic wack(input logic [8:0] v, input logic t,
                       input logic [3:0] p);
      logic [7:0] n;
      int         w;
      n = ack_cnt;
      w = 0;
      while (ack_cnt === n && w < 40) begin
         @(posedge clk);
         w++;
      end
      chk("ack_seen", 16'h0001, 16'(ack_cnt !== n));
      chk("vector", 16'(v), 16'(last_vec));
      chk("trap", 16'(t), 16'(last_trap));
      chk("prio", 16'(p), 16'(last_prio));
   endtask : wack

   //------------------------------------------------------------------
   // Clock, transfer monitor, watchdog
   //------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      if (!sys_rst && (xfer_valid === 1'b1 || cpu_stall === 1'b1)) begin
         chk("cpu_stall", 16'(xfer_valid), 16'(cpu_stall));
         xs.push_back(xfer_src);
         xd.push_back(xfer_dst);
         xw.push_back(xfer_word);
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      wrap_up();
   end

   //------------------------------------------------------------------
   // Tests
   //------------------------------------------------------------------
   initial begin
      {sys_rst, cpu_go} = 2'h3;
      {node_wr, node_enable, node_evt_en, node_set_req, chan_wr} = 5'h00;
      {chan_inc_src, chan_inc_dst, chan_word, chan_cont} = 4'h0;
      {trap_req, trap_num, ack_gap, ext_pin} = 14'h0000;
      {periph_req, chan_src, chan_dst, chan_count} = 56'h0;
      {node_sel, node_prio, cpu_level, node_evt_chan, chan_sel} = 18'h0;
      ext_edge_sel = {PIET_EDGE_OFF, PIET_EDGE_BOTH, PIET_EDGE_FALL,
                      PIET_EDGE_RISE};
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk("rst_req_bits", 16'h0000, node_request_bit);
      chk("rst_outputs", 16'h0000, 16'({irq_req, xfer_valid, cpu_stall}));
      for (int i = 0; i < 16; i++) begin
         ncfg(i, 4'h1, 1'b0, 3'h0, 1'b1);
         k = 0;
         while (irq_req !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
         end
         chk("latency", 16'h0001, 16'(k <= PIET_RESP_CYC));
         wack(vec(i), 1'b0, 4'h1);
      end
      @(posedge clk);
      {cpu_go, cpu_level, ack_gap} <= {1'b0, 4'h3, 2'h3};
      ncfg(2, 4'h5, 1'b0, 3'h0, 1'b0);
      ncfg(5, 4'h5, 1'b0, 3'h0, 1'b0);
      ncfg(7, 4'h9, 1'b0, 3'h0, 1'b0);
      ncfg(9, 4'h3, 1'b0, 3'h0, 1'b0);
      pulse(16'h02A4);
      chk("req_bits", 16'h02A4, node_request_bit);
      @(posedge clk);
      cpu_go <= 1'b1;
      wack(vec(7), 1'b0, 4'h9);
      wack(vec(2), 1'b0, 4'h5);
      wack(vec(5), 1'b0, 4'h5);
      repeat (10) @(posedge clk);
      chk("equal_level", 16'h0200, node_request_bit);
      @(posedge clk);
      {cpu_level, ack_gap} <= {4'h2, 2'h0};
      wack(vec(9), 1'b0, 4'h3);
      @(posedge clk);
      {cpu_go, cpu_level} <= {1'b0, 4'h0};
      @(posedge clk);
      {trap_req, trap_num} <= {1'b1, 7'h2A};
      @(posedge clk);
      trap_req <= 1'b0;
      ncfg(12, 4'hF, 1'b0, 3'h0, 1'b1);
      repeat (4) @(posedge clk);
      cpu_go <= 1'b1;
      wack(9'h0A8, 1'b1, 4'hF);
      wack(vec(12), 1'b0, 4'hF);
      @(posedge clk);
      ext_pin <= 4'hF;
      wack(vec(2), 1'b0, 4'h5);
      wack(vec(0), 1'b0, 4'h1);
      repeat (6) @(posedge clk);
      chk("rise_only", 16'h0000, node_request_bit);
      ext_pin <= 4'h0;
      wack(vec(2), 1'b0, 4'h5);
      wack(vec(1), 1'b0, 4'h1);
      repeat (6) @(posedge clk);
      chk("fall_only", 16'h0000, node_request_bit);
      ccfg(3'h3, 16'h1000, 16'h2000, 8'h03, 4'h8);
      ncfg(10, 4'h4, 1'b1, 3'h3, 1'b0);
      n0 = ack_cnt;
      pulse(16'h0400);
      pulse(16'h0400);
      chk("no_vector", 16'(n0), 16'(ack_cnt));
      pulse(16'h0400);
      repeat (6) @(posedge clk);
      chk("end_irq_cnt", 16'(n0 + 8'h01), 16'(ack_cnt));
      chk("end_irq_vec", 16'(vec(10)), 16'(last_vec));
      ccfg(3'h5, 16'h3000, 16'h4000, 8'h01, 4'h7);
      ncfg(11, 4'h6, 1'b1, 3'h5, 1'b0);
      pulse(16'h0800);
      pulse(16'h0800);
      repeat (6) @(posedge clk);
      chk("cont_no_irq", 16'(n0 + 8'h01), 16'(ack_cnt));
      chk("xfer_total", 16'h0005, 16'(xs.size()));
      for (int j = 0; j < 5 && j < xs.size(); j++) begin
         chk("xfer_src", es[j], xs[j]);
         chk("xfer_dst", ed[j], xd[j]);
         chk("xfer_word", 16'(ew[j]), 16'(xw[j]));
      end
      wrap_up();
   end
endmodule : tb_top

/* File: verilog/piet_ctrl.sv */
// Purpose: Priority interrupt controller with event transfer channels
// Assumes: Peripheral requests are one-cycle pulses on clk
// Notes:   Configuration arrives as write strobes, no register bus
`timescale 1ns/1ns
module piet_ctrl
   import piet_pkg::*;
#(
   parameter int NODES = PIET_NODES,
   parameter int CHANS = PIET_CHANS,
   parameter int EXT   = PIET_EXT,
   parameter int AW    = PIET_ADDR_W,
   parameter int CNTW  = PIET_CNT_W,
   localparam int NW   = $clog2(NODES),
   localparam int CW   = $clog2(CHANS),
   localparam int PW   = PIET_PRIO_W,
   localparam int TW   = PIET_TRAP_W,
   localparam int VW   = PIET_VEC_W
)(
   input  wire logic [NODES-1:0] periph_req,
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [EXT-1:0]   ext_pin,
   input  wire logic [2*EXT-1:0] ext_edge_sel,
   input  wire logic             node_wr,
   input  wire logic [NW-1:0]    node_sel,
   input  wire logic             node_enable,
   input  wire logic [PW-1:0]    node_prio,
   input  wire logic             node_evt_en,
   input  wire logic [CW-1:0]    node_evt_chan,
   input  wire logic             node_set_req,
   input  wire logic             chan_wr,
   input  wire logic [CW-1:0]    chan_sel,
   input  wire logic [AW-1:0]    chan_src,
   input  wire logic [AW-1:0]    chan_dst,
   input  wire logic [CNTW-1:0]  chan_count,
   input  wire logic             chan_inc_src,
   input  wire logic             chan_inc_dst,
   input  wire logic             chan_word,
   input  wire logic             chan_cont,
   input  wire logic [PW-1:0]    cpu_level,
   input  wire logic             cpu_ack,
   input  wire logic             trap_req,
   input  wire logic [TW-1:0]    trap_num,
   output logic                  irq_req,
   output logic [VW-1:0]         irq_vector,
   output logic [PW-1:0]         irq_prio,
   output logic                  irq_trap,
   output logic                  xfer_valid,
   output logic [AW-1:0]         xfer_src,
   output logic [AW-1:0]         xfer_dst,
   output logic                  xfer_word,
   output logic                  cpu_stall,
   output logic [NODES-1:0]      node_request_bit
);

   //------------------------------------------------------------------
   // Node and channel state
   //------------------------------------------------------------------
   logic [NODES-1:0]   req_ff, en_ff, evt_ff;
   logic [PW-1:0]      prio_ff [NODES];
   logic [CW-1:0]      ch_of_ff [NODES];
   logic [AW-1:0]      src_ff [CHANS];
   logic [AW-1:0]      dst_ff [CHANS];
   logic [CNTW-1:0]    cnt_ff [CHANS];
   logic [CHANS-1:0]   inc_s_ff, inc_d_ff, word_ff, cont_ff;
   logic               irq_req_ff, irq_trap_ff, trap_pend_ff;
   logic [VW-1:0]      irq_vector_ff;
   logic [PW-1:0]      irq_prio_ff;
   logic [NW-1:0]      irq_node_ff;
   logic [TW-1:0]      trap_num_ff;
   logic               xfer_valid_ff, xfer_word_ff, cpu_stall_ff;
   logic [AW-1:0]      xfer_src_ff, xfer_dst_ff;
   logic [EXT-1:0]     ext_evt;
   logic [NODES-1:0]   ext_set;
   logic               std_ok, evt_ok;
   logic [NW-1:0]      std_node, evt_node;
   logic [PW-1:0]      std_p, evt_p;
   logic [CW-1:0]      evt_ch;
   logic               evt_fire, do_xfer, evt_stop, ack_node;
   logic [AW-1:0]      step;
   logic [TW-1:0]      std_trap;

   //------------------------------------------------------------------
   // External inputs
   //------------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < EXT; k++) begin : g_ext
         piet_edge_det u_edge (
            .clk      (clk),
            .sys_rst  (sys_rst),
            .pin_in   (ext_pin[k]),
            .edge_sel (ext_edge_sel[2*k +: 2]),
            .evt_out  (ext_evt[k])
         );
      end
   endgenerate
   assign ext_set = {{(NODES-EXT){1'b0}}, ext_evt};

   //------------------------------------------------------------------
   // Arbitration
   //------------------------------------------------------------------
   always_comb begin
      std_ok   = 1'b0;
      evt_ok   = 1'b0;
      std_node = '0;
      evt_node = '0;
      std_p    = '0;
      evt_p    = '0;
      // Descending scan with >= leaves the lowest index on a tie
      for (int i = NODES - 1; i >= 0; i--) begin
         if (req_ff[i] && en_ff[i]) begin
            if (evt_ff[i]) begin
               if (!evt_ok || prio_ff[i] >= evt_p) begin
                  evt_ok   = 1'b1;
                  evt_node = NW'(i);
                  evt_p    = prio_ff[i];
               end
            end else if (!std_ok || prio_ff[i] >= std_p) begin
               std_ok   = 1'b1;
               std_node = NW'(i);
               std_p    = prio_ff[i];
            end
         end
      end
   end

   assign evt_ch   = ch_of_ff[evt_node];
   assign evt_fire = evt_ok && (evt_p > cpu_level);
   assign evt_stop = evt_fire && !cont_ff[evt_ch]
                     && (cnt_ff[evt_ch] <= CNTW'(1));
   assign do_xfer  = evt_fire
                     && (cont_ff[evt_ch] || cnt_ff[evt_ch] != '0);
   assign step     = word_ff[evt_ch] ? AW'(2) : AW'(1);
   assign ack_node = cpu_ack && irq_req_ff && !irq_trap_ff;
   assign std_trap = TW'(PIET_TRAP_BASE + TW'(std_node));

   //------------------------------------------------------------------
   // Node control registers
   //------------------------------------------------------------------
   genvar n;
   generate
      for (n = 0; n < NODES; n++) begin : g_node
         logic set_n, clr_n, wr_n;
         assign wr_n  = node_wr && (node_sel == NW'(n));
         assign set_n = periph_req[n] || ext_set[n]
                        || (wr_n && node_set_req);
         assign clr_n = (ack_node && irq_node_ff == NW'(n))
                        || (do_xfer && !evt_stop
                            && evt_node == NW'(n));
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               req_ff[n] <= PIET_RST_BIT;
            end else begin
               req_ff[n] <= set_n || (req_ff[n] && !clr_n);
            end
         end
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               en_ff[n]    <= PIET_RST_BIT;
               evt_ff[n]   <= PIET_RST_BIT;
               prio_ff[n]  <= '0;
               ch_of_ff[n] <= '0;
            end else if (wr_n) begin
               en_ff[n]    <= node_enable;
               evt_ff[n]   <= node_evt_en;
               prio_ff[n]  <= node_prio;
               ch_of_ff[n] <= node_evt_chan;
            end else if (evt_stop && evt_node == NW'(n)) begin
               evt_ff[n]   <= 1'b0;
            end
         end
      end
   endgenerate

   //------------------------------------------------------------------
   // Event transfer channels
   //------------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < CHANS; c++) begin : g_chan
         logic hit_c;
         assign hit_c = do_xfer && (evt_ch == CW'(c));
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               src_ff[c]   <= '0;
               dst_ff[c]   <= '0;
               cnt_ff[c]   <= '0;
               inc_s_ff[c] <= PIET_RST_BIT;
               inc_d_ff[c] <= PIET_RST_BIT;
               word_ff[c]  <= PIET_RST_BIT;
               cont_ff[c]  <= PIET_RST_BIT;
            end else if (chan_wr && chan_sel == CW'(c)) begin
               src_ff[c]   <= chan_src;
               dst_ff[c]   <= chan_dst;
               cnt_ff[c]   <= chan_count;
               inc_s_ff[c] <= chan_inc_src;
               inc_d_ff[c] <= chan_inc_dst;
               word_ff[c]  <= chan_word;
               cont_ff[c]  <= chan_cont;
            end else if (hit_c) begin
               if (inc_s_ff[c]) begin
                  src_ff[c] <= src_ff[c] + step;
               end
               if (inc_d_ff[c]) begin
                  dst_ff[c] <= dst_ff[c] + step;
               end
               if (!cont_ff[c]) begin
                  cnt_ff[c] <= cnt_ff[c] - CNTW'(1);
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xfer_valid_ff <= 1'b0;
         cpu_stall_ff  <= 1'b0;
         xfer_word_ff  <= 1'b0;
         xfer_src_ff   <= '0;
         xfer_dst_ff   <= '0;
      end else begin
         xfer_valid_ff <= do_xfer;
         cpu_stall_ff  <= do_xfer;
         xfer_word_ff  <= word_ff[evt_ch];
         xfer_src_ff   <= src_ff[evt_ch];
         xfer_dst_ff   <= dst_ff[evt_ch];
      end
   end

   //------------------------------------------------------------------
   // Traps and CPU request
   //------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trap_pend_ff <= 1'b0;
         trap_num_ff  <= '0;
      end else if (trap_req) begin
         trap_pend_ff <= 1'b1;
         trap_num_ff  <= trap_num;
      end else if (cpu_ack && irq_req_ff && irq_trap_ff) begin
         trap_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_req_ff    <= 1'b0;
         irq_trap_ff   <= 1'b0;
         irq_vector_ff <= '0;
         irq_prio_ff   <= '0;
         irq_node_ff   <= '0;
      end else if (cpu_ack && irq_req_ff) begin
         irq_req_ff    <= 1'b0;
      end else if (trap_pend_ff) begin
         irq_req_ff    <= 1'b1;
         irq_trap_ff   <= 1'b1;
         irq_vector_ff <= {trap_num_ff, PIET_VEC_LSB};
         irq_prio_ff   <= '1;
      end else if (std_ok && std_p > cpu_level) begin
         irq_req_ff    <= 1'b1;
         irq_trap_ff   <= 1'b0;
         irq_vector_ff <= {std_trap, PIET_VEC_LSB};
         irq_prio_ff   <= std_p;
         irq_node_ff   <= std_node;
      end else begin
         irq_req_ff    <= 1'b0;
      end
   end

   assign irq_req          = irq_req_ff;
   assign irq_vector       = irq_vector_ff;
   assign irq_prio         = irq_prio_ff;
   assign irq_trap         = irq_trap_ff;
   assign xfer_valid       = xfer_valid_ff;
   assign xfer_src         = xfer_src_ff;
   assign xfer_dst         = xfer_dst_ff;
   assign xfer_word        = xfer_word_ff;
   assign cpu_stall        = cpu_stall_ff;
   assign node_request_bit = req_ff;

   //------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_resp_latency : assert property (
      std_ok && std_p > cpu_level && !irq_req_ff && !trap_pend_ff
      |-> ##[1:8] irq_req_ff)
      else $error("interrupt not presented within 8 clocks");
   a_evt_routed : assert property (
      do_xfer |-> evt_ff[evt_node] && !(std_ok && std_node == evt_node))
      else $error("transfer from a node not routed to it");
   a_xfer_steal : assert property (
      do_xfer |=> xfer_valid && cpu_stall
      ##1 (!cpu_stall || $past(do_xfer)))
      else $error("transfer stall not one cycle per transfer");
   a_src_step : assert property (
      do_xfer && inc_s_ff[evt_ch] && !chan_wr
      |=> src_ff[$past(evt_ch)] == $past(src_ff[evt_ch]) + $past(step))
      else $error("source pointer not advanced");
   a_cnt_dec : assert property (
      do_xfer && !chan_wr
      |=> cnt_ff[$past(evt_ch)] == $past(cnt_ff[evt_ch])
          - ($past(cont_ff[evt_ch]) ? CNTW'(0) : CNTW'(1)))
      else $error("transfer counter wrong");
   a_stop_to_irq : assert property (
      evt_stop && !node_wr
      |=> !evt_ff[$past(evt_node)] && req_ff[$past(evt_node)])
      else $error("exhausted channel did not raise interrupt");
   a_no_low_preempt : assert property (
      $rose(irq_req_ff) && !irq_trap_ff |-> irq_prio_ff > $past(cpu_level))
      else $error("preemption by non-higher priority");
   a_node_vector : assert property (
      $rose(irq_req_ff) && !irq_trap_ff
      |-> irq_vector_ff == {$past(std_trap), PIET_VEC_LSB})
      else $error("node vector not trap number times four");
   a_trap_vector : assert property (
      trap_req && !irq_req_ff ##1 !cpu_ack
      |=> irq_req_ff && irq_trap_ff
          && irq_vector_ff == {$past(trap_num, 2), PIET_VEC_LSB})
      else $error("trap not vectored by its number");
   a_sw_set_req : assert property (
      node_wr && node_set_req |=> req_ff[$past(node_sel)])
      else $error("software request bit not set");

   c_xfer_run   : cover property (do_xfer ##1 do_xfer);
   c_chan_stop  : cover property (evt_stop ##[1:8] $rose(irq_req_ff));
   c_trap_taken : cover property (irq_trap_ff && cpu_ack);
   c_node_ack   : cover property (ack_node);

endmodule : piet_ctrl

/* File: verilog/piet_edge_det.sv */
// Purpose: Fast external input synchroniser with selectable edge
// Assumes: pin_in is asynchronous to clk
// Notes:   Level is accepted once second and third stages agree
`timescale 1ns/1ns
module piet_edge_det
   import piet_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       pin_in,
   input  wire logic [1:0] edge_sel,
   output logic            evt_out
);

   logic [2:0] sync_ff;
   logic       lvl_ff;
   logic       evt_ff;
   logic       change;
   logic       rise;
   logic       fall;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync_ff <= 3'h0;
      end else begin
         sync_ff <= {sync_ff[1:0], pin_in};
      end
   end

   assign change = (sync_ff[1] == sync_ff[2]) && (sync_ff[2] != lvl_ff);
   assign rise   = change && sync_ff[2];
   assign fall   = change && !sync_ff[2];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lvl_ff <= PIET_RST_BIT;
      end else if (change) begin
         lvl_ff <= sync_ff[2];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evt_ff <= 1'b0;
      end else begin
         evt_ff <= (rise && edge_sel[0]) || (fall && edge_sel[1]);
      end
   end

   assign evt_out = evt_ff;

   a_edge_rise_det : assert property (@(posedge clk) disable iff (sys_rst)
      rise && edge_sel == PIET_EDGE_RISE |=> evt_out)
      else $error("rising edge not reported");
   a_edge_fall_skip : assert property (@(posedge clk) disable iff (sys_rst)
      fall && edge_sel == PIET_EDGE_RISE |=> !evt_out)
      else $error("falling edge reported in rise mode");

endmodule : piet_edge_det

/* File: verilog/piet_pkg.sv */
// Purpose: Shared constants for the interrupt and event transfer block
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes:   Vector address is the trap number times four
package piet_pkg;

   //------------------------------------------------------------------
   // Sizes
   //------------------------------------------------------------------
   localparam int PIET_NODES  = 16;
   localparam int PIET_CHANS  = 8;
   localparam int PIET_PRIO_W = 4;
   localparam int PIET_TRAP_W = 7;
   localparam int PIET_VEC_W  = 9;
   localparam int PIET_ADDR_W = 16;
   localparam int PIET_CNT_W  = 8;
   localparam int PIET_EXT    = 4;

   //------------------------------------------------------------------
   // Values and timing
   //------------------------------------------------------------------
   // Trap number of node 0; arbitrary placement of the node table
   localparam logic [6:0] PIET_TRAP_BASE  = 7'h10;
   localparam logic [1:0] PIET_VEC_LSB    = 2'h0;
   localparam int         PIET_CLK_NS     = 50;
   localparam int         PIET_RESP_CYC   = 8;
   localparam logic [1:0] PIET_EDGE_OFF   = 2'h0;
   localparam logic [1:0] PIET_EDGE_RISE  = 2'h1;
   localparam logic [1:0] PIET_EDGE_FALL  = 2'h2;
   localparam logic [1:0] PIET_EDGE_BOTH  = 2'h3;
   localparam logic       PIET_RST_BIT    = 1'b0;

endpackage : piet_pkg
